// >>> pkg/drsf_pkg.sv
// Purpose: constants for the ready status flag bank
// Assumes: byte-wide register port, 16-bit addresses
// Notes: interrupt offsets sit above the status pair
package drsf_pkg;
    localparam int unsigned AW = 16;
    localparam int unsigned DW = 8;
    // register offsets
    localparam logic [15:0] DIAG_RDY_OFS = 16'h0526;
    localparam logic [15:0] ADC_RDY_OFS = 16'h0527;
    localparam logic [15:0] IRQ_STS_OFS = 16'h05f0;
    localparam logic [15:0] IRQ_MSK_OFS = 16'h05f1;
    localparam logic [15:0] IRQ_MSK2_OFS = 16'h05f2;
    // diagnostic ready fields
    localparam int unsigned SUP_BIT = 0;
    localparam int unsigned VBIST_BIT = 1;
    localparam int unsigned TBIST_BIT = 2;
    localparam int unsigned VRR_BIT = 3;
    localparam int unsigned TRR_BIT = 4;
    // adc ready fields
    localparam int unsigned MAIN_BIT = 0;
    localparam int unsigned MISC_BIT = 1;
    localparam int unsigned CELL_BIT = 2;
    localparam int unsigned PIN_BIT = 3;
    // check modes
    localparam logic [1:0] MODE_RR = 2'h1;
    localparam logic [1:0] MODE_BIST = 2'h2;
    // reset values
    localparam logic [4:0] DIAG_RST = 5'h00;
    localparam logic [3:0] ADC_RST = 4'h0;
    localparam logic [8:0] MSK_RST = 9'h000;
endpackage

// >>> rtl/drsf_ready_flags.sv
// Purpose: ready flags for protector checks, self-tests and adc sweeps
// Assumes: all inputs synchronous to i_clk, strobes one cycle long
// Notes: irq status bits 0-4 follow diag flags, 5-8 follow adc flags
`timescale 1ns/1ps
module drsf_ready_flags
    import drsf_pkg::*;
#(
    parameter int unsigned N_PIN = 8,
    parameter int unsigned N_CELL = 16
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // register port
    input wire logic [AW-1:0] i_addr,
    input wire logic [DW-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [DW-1:0] o_rdata,
    // check and self-test starts
    input wire logic i_temp_check_start,
    input wire logic [1:0] i_temp_check_mode,
    input wire logic i_volt_check_start,
    input wire logic [1:0] i_volt_check_mode,
    input wire logic i_supply_selftest_start,
    // completion events
    input wire logic i_temp_rr_done,
    input wire logic i_volt_rr_done,
    input wire logic i_temp_bist_done,
    input wire logic i_volt_bist_done,
    input wire logic i_supply_bist_done,
    // aux adc
    input wire logic i_aux_go,
    input wire logic [N_PIN-1:0] i_aux_pin_active,
    input wire logic i_aux_pin_conv,
    input wire logic [$clog2(N_PIN)-1:0] i_aux_pin_chan,
    input wire logic [4:0] i_aux_cellchannel_select,
    input wire logic i_aux_cell_conv,
    input wire logic [$clog2(N_CELL)-1:0] i_aux_cell_chan,
    input wire logic i_aux_misc_pass_done,
    // main adc
    input wire logic i_main_go,
    input wire logic i_main_pass_done,
    // interrupt
    output logic o_irq
);

    typedef struct packed {
        logic [4:0] diag;
        logic [3:0] adc;
        logic [N_PIN-1:0] pin_seen;
        logic [N_CELL-1:0] cell_seen;
        logic aux_go;
        logic main_go;
        logic [8:0] sts;
        logic [8:0] msk;
        logic [DW-1:0] rdata;
        logic irq;
    } drsf_state_t;

    drsf_state_t st_q;
    drsf_state_t st_d;

    // cells 0..sel are wanted; sel beyond the top wants all
    function automatic logic [N_CELL-1:0] cell_need(input logic [4:0] sel);
        logic [N_CELL-1:0] m;
        m = '0;
        for (int i = 0; i < N_CELL; i++) begin
            m[i] = (5'(i) <= sel);
        end
        return m;
    endfunction

    function automatic logic hit(input logic [AW-1:0] a, input logic [15:0] o);
        return a == o;
    endfunction

    logic aux_rise;
    logic main_rise;
    logic t_rr_clr;
    logic t_bi_clr;
    logic v_rr_clr;
    logic v_bi_clr;
    logic [N_PIN-1:0] pin_now;
    logic [N_CELL-1:0] cell_now;
    logic [4:0] diag_set;
    logic [3:0] adc_set;
    logic [8:0] evt;

    always_comb begin
        st_d = st_q;
        aux_rise = i_aux_go & ~st_q.aux_go;
        main_rise = i_main_go & ~st_q.main_go;
        t_rr_clr = i_temp_check_start && i_temp_check_mode == MODE_RR;
        t_bi_clr = i_temp_check_start && i_temp_check_mode == MODE_BIST;
        v_rr_clr = i_volt_check_start && i_volt_check_mode == MODE_RR;
        v_bi_clr = i_volt_check_start && i_volt_check_mode == MODE_BIST;
        st_d.aux_go = i_aux_go;
        st_d.main_go = i_main_go;

        // per-channel coverage, restarted with each aux run
        // pin and cell coverage
        pin_now = aux_rise ? '0 : st_q.pin_seen;
        if (i_aux_pin_conv) begin
            pin_now[i_aux_pin_chan] = 1'b1;
        end
        cell_now = aux_rise ? '0 : st_q.cell_seen;
        if (i_aux_cell_conv) begin
            cell_now[i_aux_cell_chan] = 1'b1;
        end
        st_d.pin_seen = pin_now;
        st_d.cell_seen = cell_now;

        diag_set = '0;
        diag_set[TRR_BIT] = i_temp_rr_done;
        diag_set[VRR_BIT] = i_volt_rr_done;
        diag_set[TBIST_BIT] = i_temp_bist_done;
        diag_set[VBIST_BIT] = i_volt_bist_done;
        diag_set[SUP_BIT] = i_supply_bist_done;

        // coverage only counts while the aux run is on
        adc_set = '0;
        adc_set[PIN_BIT] = i_aux_go && ((i_aux_pin_active & ~pin_now) == '0);
        adc_set[CELL_BIT] = i_aux_go
            && ((cell_need(i_aux_cellchannel_select) & ~cell_now) == '0);
        adc_set[MISC_BIT] = i_aux_misc_pass_done;
        adc_set[MAIN_BIT] = i_main_pass_done;

        if (t_rr_clr) begin
            st_d.diag[TRR_BIT] = 1'b0;
        end
        if (v_rr_clr) begin
            st_d.diag[VRR_BIT] = 1'b0;
        end
        if (t_bi_clr) begin
            st_d.diag[TBIST_BIT] = 1'b0;
        end
        if (v_bi_clr) begin
            st_d.diag[VBIST_BIT] = 1'b0;
        end
        if (i_supply_selftest_start) begin
            st_d.diag[SUP_BIT] = 1'b0;
        end
        if (aux_rise) begin
            st_d.adc[PIN_BIT] = 1'b0;
            st_d.adc[CELL_BIT] = 1'b0;
            st_d.adc[MISC_BIT] = 1'b0;
        end
        if (main_rise) begin
            st_d.adc[MAIN_BIT] = 1'b0;
        end
        // all done events set their flags
        // completion beats a same-cycle start so no event is lost
        st_d.diag = st_d.diag | diag_set;
        st_d.adc = st_d.adc | adc_set;

        // interrupt events on each flag rising
        evt = {st_d.adc & ~st_q.adc, st_d.diag & ~st_q.diag};

        st_d.rdata = '0;
        if (i_rd) begin
            if (hit(i_addr, DIAG_RDY_OFS)) begin
                st_d.rdata = {3'h0, st_q.diag};
            end else if (hit(i_addr, ADC_RDY_OFS)) begin
                st_d.rdata = {4'h0, st_q.adc};
            end else if (hit(i_addr, IRQ_STS_OFS)) begin
                st_d.rdata = st_q.sts[7:0];
                st_d.sts = '0;
            end else if (hit(i_addr, IRQ_MSK_OFS)) begin
                st_d.rdata = st_q.msk[7:0];
            end else if (hit(i_addr, IRQ_MSK2_OFS)) begin
                st_d.rdata = {7'h00, st_q.msk[8]};
            end else if (hit(i_addr, IRQ_MSK2_OFS + 16'h0001)) begin
                // top status bit; read of the low byte clears both
                st_d.rdata = {7'h00, st_q.sts[8]};
            end
        end
        if (i_wr) begin
            if (hit(i_addr, IRQ_MSK_OFS)) begin
                st_d.msk[7:0] = i_wdata;
            end else if (hit(i_addr, IRQ_MSK2_OFS)) begin
                st_d.msk[8] = i_wdata[0];
            end
        end
        st_d.sts = st_d.sts | evt;
        st_d.irq = |(st_d.sts & st_d.msk);
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st_q <= '0;
            st_q.msk <= MSK_RST;
            st_q.diag <= DIAG_RST;
            st_q.adc <= ADC_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_rdata = st_q.rdata;
    assign o_irq = st_q.irq;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);

    a_temp_rr_clear: assert property (
        t_rr_clr && !i_temp_rr_done |=> !st_q.diag[TRR_BIT])
        else $error("temp pass flag not cleared");
    a_volt_rr_clear: assert property (
        v_rr_clr && !i_volt_rr_done |=> !st_q.diag[VRR_BIT])
        else $error("volt pass flag not cleared");
    a_temp_bist_flow: assert property (
        i_temp_bist_done |=> st_q.diag[TBIST_BIT])
        else $error("temp self-test flag not set");
    a_volt_bist_keep: assert property (
        !v_bi_clr && st_q.diag[VBIST_BIT] |=> st_q.diag[VBIST_BIT])
        else $error("volt self-test flag lost");
    a_supply_clear: assert property (
        i_supply_selftest_start && !i_supply_bist_done
        |=> !st_q.diag[SUP_BIT])
        else $error("supply flag not cleared");
    a_pin_sweep_set: assert property (
        $rose(st_q.adc[PIN_BIT]) |-> $past(i_aux_go))
        else $error("pin flag set without aux run");
    a_cell_clear: assert property (
        aux_rise && !adc_set[CELL_BIT] |=> !st_q.adc[CELL_BIT])
        else $error("cell flag not cleared");
    a_misc_clear: assert property (
        aux_rise && !i_aux_misc_pass_done |=> !st_q.adc[MISC_BIT])
        else $error("misc flag not cleared");
    a_main_set: assert property (
        i_main_pass_done |=> st_q.adc[MAIN_BIT])
        else $error("main flag not set");
    a_main_held_high: assert property (
        st_q.main_go && i_main_go && st_q.adc[MAIN_BIT]
        |=> st_q.adc[MAIN_BIT])
        else $error("main flag cleared without edge");
    a_reserved_bits_zero: assert property (
        i_rd && hit(i_addr, DIAG_RDY_OFS) |=> o_rdata[7:5] == 3'h0)
        else $error("reserved bits not zero");
    a_status_ro: assert property (
        i_wr && hit(i_addr, ADC_RDY_OFS) && !(|adc_set) && !aux_rise
        && !main_rise |=> $stable(st_q.adc))
        else $error("status changed by write");

    a_temp_rr_set: assert property (
        i_temp_rr_done |=> st_q.diag[TRR_BIT])
        else $error("temp pass flag not set");
    a_temp_rr_keep: assert property (
        !t_rr_clr && st_q.diag[TRR_BIT] |=> st_q.diag[TRR_BIT])
        else $error("temp pass flag lost");
    a_volt_rr_set: assert property (
        i_volt_rr_done |=> st_q.diag[VRR_BIT])
        else $error("volt pass flag not set");
    a_volt_rr_keep: assert property (
        !v_rr_clr && st_q.diag[VRR_BIT] |=> st_q.diag[VRR_BIT])
        else $error("volt pass flag lost");
    a_temp_bist_clear: assert property (
        t_bi_clr && !i_temp_bist_done |=> !st_q.diag[TBIST_BIT])
        else $error("temp self-test flag not cleared");
    a_volt_bist_clear: assert property (
        v_bi_clr && !i_volt_bist_done |=> !st_q.diag[VBIST_BIT])
        else $error("volt self-test flag not cleared");
    a_volt_bist_set: assert property (
        i_volt_bist_done |=> st_q.diag[VBIST_BIT])
        else $error("volt self-test flag not set");
    a_supply_set: assert property (
        i_supply_bist_done |=> st_q.diag[SUP_BIT])
        else $error("supply flag not set");
    a_supply_keep: assert property (
        !i_supply_selftest_start && st_q.diag[SUP_BIT] |=> st_q.diag[SUP_BIT])
        else $error("supply flag lost");
    a_pin_clear: assert property (
        aux_rise && !adc_set[PIN_BIT] |=> !st_q.adc[PIN_BIT])
        else $error("pin flag not cleared");
    a_pin_keep: assert property (
        !aux_rise && st_q.adc[PIN_BIT] |=> st_q.adc[PIN_BIT])
        else $error("pin flag lost");
    a_cell_sweep_set: assert property (
        $rose(st_q.adc[CELL_BIT]) |-> $past(i_aux_go))
        else $error("cell flag set without aux run");
    a_misc_set: assert property (
        i_aux_misc_pass_done |=> st_q.adc[MISC_BIT])
        else $error("misc flag not set");
    a_misc_keep: assert property (
        !aux_rise && st_q.adc[MISC_BIT] |=> st_q.adc[MISC_BIT])
        else $error("misc flag lost");
    a_main_event: assert property (
        i_main_pass_done && !st_q.adc[MAIN_BIT] |=> st_q.sts[5])
        else $error("main event not latched");
    a_main_clear: assert property (
        main_rise && !i_main_pass_done |=> !st_q.adc[MAIN_BIT])
        else $error("main flag not cleared on edge");
    a_reset_zero: assert property (
        $fell(i_srst) |-> st_q.diag == '0 && st_q.adc == '0)
        else $error("flags not zero after reset");
    a_rdata_idle: assert property (
        !i_rd |=> o_rdata == 8'h00)
        else $error("read data not idle");
    a_sts_read_clear: assert property (
        i_rd && hit(i_addr, IRQ_STS_OFS) && evt == '0 |=> st_q.sts == '0)
        else $error("status not cleared by read");
    a_msk_write: assert property (
        i_wr && hit(i_addr, IRQ_MSK_OFS) |=> st_q.msk[7:0] == $past(i_wdata))
        else $error("mask not written");
    a_msk_top_write: assert property (
        i_wr && hit(i_addr, IRQ_MSK2_OFS) |=> st_q.msk[8] == $past(i_wdata[0]))
        else $error("top mask bit not written");

    c_aux_sweep: cover property (aux_rise ##[1:50] st_q.adc[PIN_BIT]);
    c_temp_bist: cover property (t_bi_clr ##[1:50] st_q.diag[TBIST_BIT]);
    c_irq_read: cover property (o_irq ##1 i_rd && hit(i_addr, IRQ_STS_OFS));
    c_main_restart: cover property (main_rise ##[1:50] st_q.adc[MAIN_BIT]);
    c_pin_empty: cover property (i_aux_go && i_aux_pin_active == '0 ##1 st_q.adc[PIN_BIT]);

endmodule

// >>> sim/drsf_tb.sv
// Purpose: self-checking bench for the ready flag bank
// Assumes: default pin and cell counts, pins 0 and 2 active, cells 0..1 wanted at first
// Notes: pv bits 0-4 are diag done events, 5 pin, 6 cell, 7 misc, 8 main pass
`timescale 1ns/1ps
module testbench import drsf_pkg::*;;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic [AW-1:0] i_addr = '0;
    logic [DW-1:0] i_wdata = '0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [8:0] pv = '0;
    logic [2:0] st = '0;
    logic [1:0] md = '0;
    logic [3:0] ch = '0;
    logic aux_go = 1'b0;
    logic main_go = 1'b0;
    logic [7:0] pin_act = 8'h05;
    logic [4:0] cell_sel = 5'h01;
    logic [DW-1:0] o_rdata;
    logic o_irq;
    int fails = 0;
    int checks = 0;
    int cyc = 0;

    always #12.5 i_clk = ~i_clk;

    drsf_ready_flags u_drsf_ready_flags (
        .i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_temp_check_start(st[2]), .i_temp_check_mode(md),
        .i_volt_check_start(st[1]), .i_volt_check_mode(md),
        .i_supply_selftest_start(st[0]),
        .i_temp_rr_done(pv[TRR_BIT]), .i_volt_rr_done(pv[VRR_BIT]),
        .i_temp_bist_done(pv[TBIST_BIT]), .i_volt_bist_done(pv[VBIST_BIT]),
        .i_supply_bist_done(pv[SUP_BIT]),
        .i_aux_go(aux_go), .i_aux_pin_active(pin_act), .i_aux_pin_conv(pv[5]),
        .i_aux_pin_chan(ch[2:0]), .i_aux_cellchannel_select(cell_sel),
        .i_aux_cell_conv(pv[6]), .i_aux_cell_chan(ch), .i_aux_misc_pass_done(pv[7]),
        .i_main_go(main_go), .i_main_pass_done(pv[8]), .o_irq(o_irq)
    );

    task chk(input string n, input logic [7:0] e, input logic [7:0] s);
        checks++;
        if (s !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    // read data stands only in the cycle after the strobe
    task rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk("rdata", e, o_rdata);
    endtask

    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task pulse(input int i, input logic [3:0] c);
        @(posedge i_clk);
        pv[i] <= 1'b1;
        ch <= c;
        @(posedge i_clk);
        pv <= '0;
    endtask

    task start(input logic [2:0] s, input logic [1:0] m);
        @(posedge i_clk);
        st <= s;
        md <= m;
        @(posedge i_clk);
        st <= '0;
    endtask

    task irq_is(input logic e);
        @(posedge i_clk);
        #1 chk("irq", {7'h00, e}, {7'h00, o_irq});
    endtask

    task end_sim;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // whole run is a little over a hundred cycles
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            end_sim;
        end
    end

    initial begin
        repeat (5) @(posedge i_clk);
        i_srst <= 1'b0;
        rd(DIAG_RDY_OFS, 8'h00);
        rd(ADC_RDY_OFS, 8'h00);
        wr(DIAG_RDY_OFS, 8'hff);
        wr(ADC_RDY_OFS, 8'hff);
        rd(DIAG_RDY_OFS, 8'h00);
        rd(ADC_RDY_OFS, 8'h00);
        rd(16'h0600, 8'h00);
        $display("test read-only done");
        wr(IRQ_MSK_OFS, 8'h04);
        rd(IRQ_MSK_OFS, 8'h04);
        pulse(SUP_BIT, 4'h0);
        irq_is(1'b0);
        pulse(TBIST_BIT, 4'h0);
        irq_is(1'b1);
        rd(IRQ_STS_OFS, 8'h05);
        irq_is(1'b0);
        $display("test interrupt done");
        for (int i = 0; i < 5; i++) begin
            pulse(i, 4'h0);
        end
        rd(DIAG_RDY_OFS, 8'h1f);
        @(posedge i_clk);
        #1 chk("rdata idle", 8'h00, o_rdata);
        start(3'b110, 2'h3);
        rd(DIAG_RDY_OFS, 8'h1f);
        start(3'b100, MODE_RR);
        rd(DIAG_RDY_OFS, 8'h0f);
        start(3'b100, MODE_BIST);
        rd(DIAG_RDY_OFS, 8'h0b);
        start(3'b010, MODE_RR);
        rd(DIAG_RDY_OFS, 8'h03);
        start(3'b010, MODE_BIST);
        rd(DIAG_RDY_OFS, 8'h01);
        start(3'b001, 2'h0);
        rd(DIAG_RDY_OFS, 8'h00);
        $display("test diag flags done");
        @(posedge i_clk);
        aux_go <= 1'b1;
        pulse(5, 4'h0);
        rd(ADC_RDY_OFS, 8'h00);
        pulse(5, 4'h2);
        rd(ADC_RDY_OFS, 8'h08);
        pulse(6, 4'h1);
        rd(ADC_RDY_OFS, 8'h08);
        pulse(6, 4'h0);
        rd(ADC_RDY_OFS, 8'h0c);
        pulse(7, 4'h0);
        rd(ADC_RDY_OFS, 8'h0e);
        @(posedge i_clk);
        aux_go <= 1'b0;
        @(posedge i_clk);
        aux_go <= 1'b1;
        rd(ADC_RDY_OFS, 8'h00);
        $display("test aux flags done");
        @(posedge i_clk);
        main_go <= 1'b1;
        pulse(8, 4'h0);
        rd(ADC_RDY_OFS, 8'h01);
        // held high is no new start
        rd(ADC_RDY_OFS, 8'h01);
        @(posedge i_clk);
        main_go <= 1'b0;
        rd(ADC_RDY_OFS, 8'h01);
        @(posedge i_clk);
        main_go <= 1'b1;
        rd(ADC_RDY_OFS, 8'h00);
        $display("test main flag done");
        @(posedge i_clk);
        pin_act <= 8'h00;
        cell_sel <= 5'h00;
        rd(ADC_RDY_OFS, 8'h08);
        pulse(6, 4'h0);
        rd(ADC_RDY_OFS, 8'h0c);
        rd(IRQ_MSK2_OFS + 16'h0001, 8'h01);
        wr(IRQ_MSK2_OFS, 8'h01);
        irq_is(1'b1);
        rd(IRQ_MSK2_OFS, 8'h01);
        rd(IRQ_STS_OFS, 8'hfa);
        irq_is(1'b0);
        rd(IRQ_MSK2_OFS + 16'h0001, 8'h00);
        $display("test masks and top irq bit done");
        end_sim;
    end
endmodule
